// ===== design/rcs_defines.vh
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// Register indices; byte address is four times the index
`define RCS_IDX_EVENT_FLAGS      6'h01
`define RCS_IDX_CLOCK_OUTPUT     6'h03
`define RCS_IDX_POWER_MODE       6'h0F

// event_flags_and_irq_enables fields
`define RCS_BIT_PERIODIC_TICK    7
`define RCS_BIT_WATCHDOG         6
`define RCS_BIT_TAMPER_GROUND    5
`define RCS_BIT_ALARM            4
`define RCS_BIT_COUNTDOWN        3
`define RCS_BIT_STAMP_IRQ_EN     2
`define RCS_BIT_ALARM_IRQ_EN     1
`define RCS_BIT_COUNTDOWN_IRQ_EN 0

// power_mode_and_battery_flags fields
`define RCS_POWER_MODE_HI        7
`define RCS_POWER_MODE_LO        5
`define RCS_BIT_SWITCHOVER_STAMP 4
`define RCS_BIT_SWITCHOVER       3
`define RCS_BIT_LOW_BATTERY      2
`define RCS_BIT_SWITCHOVER_IRQ   1
`define RCS_BIT_LOW_BATT_IRQ     0

// clock_output_and_temp_period fields
`define RCS_TEMP_PERIOD_HI       7
`define RCS_TEMP_PERIOD_LO       6
`define RCS_FREQ_SEL_HI          2
`define RCS_FREQ_SEL_LO          0

// Reset values
`define RCS_RST_EVENT_FLAGS      8'h00
`define RCS_RST_POWER_MODE       3'h0
`define RCS_RST_POWER_CTRL       8'h00
`define RCS_RST_TEMP_PERIOD      2'h0
`define RCS_RST_FREQ_SEL         3'h0

// Output frequency codes
`define RCS_FREQ_32K             3'h0
`define RCS_FREQ_1HZ             3'h6
`define RCS_FREQ_OFF             3'h7

// Temperature measurement periods in seconds per select code
`define RCS_TEMP_SEC_00          8'hF0
`define RCS_TEMP_SEC_01          8'h78
`define RCS_TEMP_SEC_10          8'h3C
`define RCS_TEMP_SEC_11          8'h1E

// Oscillator divider: bit 14 toggles every half second, giving 1 Hz
`define RCS_DIV_W                15

// Bus responses
`define RCS_RESP_OKAY            2'h0
`define RCS_RESP_SLVERR          2'h2

`endif

// ===== design/rcs_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.vh"

// Notes on behaviour
// - Periodic tick event sets bit 7 of event register; software clears it.
// - Watchdog event sets bit 6; read-only, bus cannot clear it.
// - Stamp pin pulled to ground sets bit 5, held until software clears.
// - Alarm sets bit 4, held until software clears; clearing drops interrupt.
// - Countdown timer event sets bit 3, held until software clears.
// - Bit 2 enables interrupt from the stamp flag.
// - Bit 1 enables interrupt from the alarm flag.
// - Bit 0 enables interrupt from the countdown flag.
// - Power register bits 7..5 select power management mode.
// - Power register bit 4 requests a stamp on battery switch-over.
// - Switch-over sets power register bit 3, held until software clears.
// - Bit 2 shows live battery-low status; writes cannot clear it.
// - Bit 1 enables interrupt from the switch-over flag.
// - Bit 0 enables interrupt from the battery-low flag.
// - Clock output register: temp period bits 7..6, frequency bits 2..0.
// - Temperature measurement at reset, then every 4, 2, 1 min or 30 s.
// - Frequency select picks square wave from 32.768 kHz down to 1 Hz.
// - Square wave pin is open drain, enabled at reset, else high-Z.
// - All divided frequencies have equal high and low times.
// - Codes 000..110 give 32768..1024 Hz and 1 Hz; 111 is high-Z.
// - Unimplemented bits read as zero.
module rcs_regs (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Event sources, one-cycle pulses
    input  wire        tick_event,
    input  wire        watchdog_event,
    input  wire        stamp_ground_event,
    input  wire        alarm_event,
    input  wire        countdown_event,
    input  wire        switchover_event,
    // Battery status level
    input  wire        battery_low,
    // Oscillator level, sampled on aclk
    input  wire        osc_32k,
    // Block outputs
    output reg         irq_q,
    output reg  [2:0]  power_mode_field,
    output reg         switchover_stamp_req,
    output reg         temp_meas_start,
    output reg         square_wave_pin_out,
    output reg         square_wave_pin_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function [7:0] temp_period_sec;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    temp_period_sec = `RCS_TEMP_SEC_00;
                2'h1:    temp_period_sec = `RCS_TEMP_SEC_01;
                2'h2:    temp_period_sec = `RCS_TEMP_SEC_10;
                default: temp_period_sec = `RCS_TEMP_SEC_11;
            endcase
        end
    endfunction

    function mapped;
        input [5:0] idx;
        begin
            mapped = (idx == `RCS_IDX_EVENT_FLAGS) || (idx == `RCS_IDX_CLOCK_OUTPUT) ||
                     (idx == `RCS_IDX_POWER_MODE);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register state

    reg        periodic_tick_flag_q;
    reg        watchdog_event_flag_q;
    reg        tamper_ground_flag_q;
    reg        alarm_flag_q;
    reg        countdown_flag_q;
    reg        stamp_irq_enable_q;
    reg        alarm_irq_enable_q;
    reg        countdown_irq_enable_q;
    reg        switchover_stamp_enable_q;
    reg        switchover_flag_q;
    reg        low_battery_flag_q;
    reg        switchover_irq_enable_q;
    reg        low_battery_irq_enable_q;
    reg  [1:0] temp_period_select_q;
    reg  [2:0] output_freq_select_q;

    wire [5:0] wr_idx   = s_axi_awaddr[7:2];
    wire [5:0] rd_idx   = s_axi_araddr[7:2];
    wire       wr_fire  = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    wire       wr_lane  = wr_fire & s_axi_wstrb[0] & (s_axi_awaddr[1:0] == 2'h0);
    wire       wr_evt   = wr_lane & (wr_idx == `RCS_IDX_EVENT_FLAGS);
    wire       wr_pwr   = wr_lane & (wr_idx == `RCS_IDX_POWER_MODE);
    wire       wr_clk   = wr_lane & (wr_idx == `RCS_IDX_CLOCK_OUTPUT);
    wire [7:0] wd       = s_axi_wdata[7:0];

    wire [7:0] evt_reg  = {periodic_tick_flag_q, watchdog_event_flag_q, tamper_ground_flag_q,
                           alarm_flag_q, countdown_flag_q, stamp_irq_enable_q,
                           alarm_irq_enable_q, countdown_irq_enable_q};
    wire [7:0] pwr_reg  = {power_mode_field, switchover_stamp_enable_q, switchover_flag_q,
                           low_battery_flag_q, switchover_irq_enable_q, low_battery_irq_enable_q};
    wire [7:0] clk_reg  = {temp_period_select_q, 3'h0, output_freq_select_q};

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: address and data accepted together, one write at a time

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RCS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RCS_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (mapped(wr_idx) && s_axi_awaddr[1:0] == 2'h0) ?
                                `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arready & s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RCS_RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr[1:0] != 2'h0 || !mapped(rd_idx))
                    s_axi_rresp <= `RCS_RESP_SLVERR;
                else if (rd_idx == `RCS_IDX_EVENT_FLAGS)
                    s_axi_rdata <= {24'h00_0000, evt_reg};
                else if (rd_idx == `RCS_IDX_POWER_MODE)
                    s_axi_rdata <= {24'h00_0000, pwr_reg};
                else
                    s_axi_rdata <= {24'h00_0000, clk_reg};
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags and enables; an event in the clearing cycle wins

    always @(posedge aclk) begin
        if (!aresetn) begin
            {periodic_tick_flag_q, watchdog_event_flag_q, tamper_ground_flag_q, alarm_flag_q,
             countdown_flag_q, stamp_irq_enable_q, alarm_irq_enable_q,
             countdown_irq_enable_q} <= `RCS_RST_EVENT_FLAGS;
            power_mode_field          <= `RCS_RST_POWER_MODE;
            switchover_stamp_enable_q <= 1'b0;
            switchover_flag_q         <= 1'b0;
            low_battery_flag_q        <= 1'b0;
            switchover_irq_enable_q   <= 1'b0;
            low_battery_irq_enable_q  <= 1'b0;
            temp_period_select_q      <= `RCS_RST_TEMP_PERIOD;
            output_freq_select_q      <= `RCS_RST_FREQ_SEL;
        end else begin
            periodic_tick_flag_q  <= tick_event | (periodic_tick_flag_q &
                                     ~(wr_evt & ~wd[`RCS_BIT_PERIODIC_TICK]));
            watchdog_event_flag_q <= watchdog_event | watchdog_event_flag_q;
            tamper_ground_flag_q  <= stamp_ground_event | (tamper_ground_flag_q &
                                     ~(wr_evt & ~wd[`RCS_BIT_TAMPER_GROUND]));
            alarm_flag_q          <= alarm_event | (alarm_flag_q &
                                     ~(wr_evt & ~wd[`RCS_BIT_ALARM]));
            countdown_flag_q      <= countdown_event | (countdown_flag_q &
                                     ~(wr_evt & ~wd[`RCS_BIT_COUNTDOWN]));
            switchover_flag_q     <= switchover_event | (switchover_flag_q &
                                     ~(wr_pwr & ~wd[`RCS_BIT_SWITCHOVER]));
            low_battery_flag_q    <= battery_low;
            if (wr_evt) begin
                stamp_irq_enable_q     <= wd[`RCS_BIT_STAMP_IRQ_EN];
                alarm_irq_enable_q     <= wd[`RCS_BIT_ALARM_IRQ_EN];
                countdown_irq_enable_q <= wd[`RCS_BIT_COUNTDOWN_IRQ_EN];
            end
            if (wr_pwr) begin
                power_mode_field          <= wd[`RCS_POWER_MODE_HI:`RCS_POWER_MODE_LO];
                switchover_stamp_enable_q <= wd[`RCS_BIT_SWITCHOVER_STAMP];
                switchover_irq_enable_q   <= wd[`RCS_BIT_SWITCHOVER_IRQ];
                low_battery_irq_enable_q  <= wd[`RCS_BIT_LOW_BATT_IRQ];
            end
            if (wr_clk) begin
                temp_period_select_q <= wd[`RCS_TEMP_PERIOD_HI:`RCS_TEMP_PERIOD_LO];
                output_freq_select_q <= wd[`RCS_FREQ_SEL_HI:`RCS_FREQ_SEL_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and stamp request
    // Tick and watchdog flags drive the interrupt directly; they have no enable bit.

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_q                <= 1'b0;
            switchover_stamp_req <= 1'b0;
        end else begin
            irq_q <= periodic_tick_flag_q | watchdog_event_flag_q |
                     (tamper_ground_flag_q & stamp_irq_enable_q) |
                     (alarm_flag_q & alarm_irq_enable_q) |
                     (countdown_flag_q & countdown_irq_enable_q) |
                     (switchover_flag_q & switchover_irq_enable_q) |
                     (low_battery_flag_q & low_battery_irq_enable_q);
            switchover_stamp_req <= switchover_event & switchover_stamp_enable_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator divider, square wave and temperature scheduler

    reg                  osc_prev_q;
    reg  [`RCS_DIV_W-1:0] div_q;
    reg  [7:0]           sec_q;
    reg                  meas_pending_q;
    wire                 osc_rise = osc_32k & ~osc_prev_q;
    wire                 sec_tick = osc_rise & (&div_q);
    reg                  wave_d;

    always @* begin
        case (output_freq_select_q)
            `RCS_FREQ_32K: wave_d = osc_32k; // Undivided, duty follows oscillator
            3'h1:    wave_d = div_q[0];
            3'h2:    wave_d = div_q[1];
            3'h3:    wave_d = div_q[2];
            3'h4:    wave_d = div_q[3];
            3'h5:    wave_d = div_q[4];
            `RCS_FREQ_1HZ: wave_d = div_q[14];
            default: wave_d = 1'b1;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_prev_q          <= 1'b0;
            div_q               <= {`RCS_DIV_W{1'b0}};
            sec_q               <= 8'h00;
            meas_pending_q      <= 1'b1;
            temp_meas_start     <= 1'b0;
            square_wave_pin_out <= 1'b0;
            square_wave_pin_oe  <= 1'b0;
        end else begin
            osc_prev_q <= osc_32k;
            if (osc_rise)
                div_q <= div_q + {{(`RCS_DIV_W-1){1'b0}}, 1'b1};
            // First measurement right after reset, then on the period
            temp_meas_start <= meas_pending_q;
            meas_pending_q  <= 1'b0;
            if (sec_tick) begin
                if (sec_q + 8'h01 >= temp_period_sec(temp_period_select_q)) begin
                    sec_q          <= 8'h00;
                    meas_pending_q <= 1'b1;
                end else begin
                    sec_q <= sec_q + 8'h01;
                end
            end
            // Open drain: pull low only; high level comes from the pull-up
            square_wave_pin_out <= 1'b0;
            square_wave_pin_oe  <= (output_freq_select_q != `RCS_FREQ_OFF) & ~wave_d;
        end
    end

endmodule // rcs_regs

`default_nettype wire

// ===== tb/rcs_host.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    int timeouts = 0;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
////////////////////////////////////////
    // Values read here are those sampled at the edge
    task automatic wait_hi(input int k);
        int n;
        logic [3:0] s;
        n = 0;
        do begin
            @(posedge aclk);
            s = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready & s_axi_wready};
            n++;
        end while (!s[k] && n < 64);
        if (n >= 64) timeouts++;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        wait_hi(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        // Released lines must not keep a value the slave could reuse
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~{24'h00_0000, d};
        // Late ready makes the slave hold its response for a cycle
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        wait_hi(1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        wait_hi(2);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        wait_hi(3);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule // rcs_host
`default_nettype wire

// ===== tb/rcs_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_regs_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Events and block outputs
    input wire logic        tick_event,
    input wire logic        watchdog_event,
    input wire logic        switchover_event,
    input wire logic        irq_q,
    input wire logic        switchover_stamp_req,
    input wire logic        temp_meas_start,
    input wire logic        square_wave_pin_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
////////////////////////////////////////
    chk_write_taken: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
        |=> s_axi_awready && s_axi_wready) else $error("write not taken one cycle after valid");
    chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before rready");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    chk_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read carries data");
    chk_tick_irq: assert property (tick_event |-> ##2 irq_q)
        else $error("tick event raised no interrupt");
    chk_watchdog_sticks: assert property (watchdog_event |-> ##2 irq_q [*8])
        else $error("watchdog interrupt not held");
    chk_stamp_cause: assert property (switchover_stamp_req |-> $past(switchover_event))
        else $error("stamp request without switch-over");
    chk_temp_pulse: assert property (temp_meas_start |=> !temp_meas_start)
        else $error("measurement start longer than one cycle");
    chk_pin_drain: assert property (!square_wave_pin_out)
        else $error("open-drain pin driven high");
endmodule // rcs_regs_monitor
`default_nettype wire

// ===== tb/rcs_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcs_defines.vh"
module rcs_regs_test;
    localparam logic [7:0] a_ev = {`RCS_IDX_EVENT_FLAGS, 2'b00};
    localparam logic [7:0] a_ck = {`RCS_IDX_CLOCK_OUTPUT, 2'b00};
    localparam logic [7:0] a_pw = {`RCS_IDX_POWER_MODE, 2'b00};
    logic aclk = 1'b0, aresetn = 1'b0, battery_low = 1'b0, osc_32k = 1'b0;
    logic temp_seen = 1'b0;
    logic [5:0] ev = '0;
    logic [1:0] osc_div = '0, resp;
    logic [31:0] rdat;
    int err_count = 0, samples_checked = 0, h1, h2, stamp_cnt = 0;
    wire [7:0] s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0] s_axi_wstrb;
    wire [2:0] power_mode_field;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_q, switchover_stamp_req;
    wire temp_meas_start, square_wave_pin_out, square_wave_pin_oe;
    always #12.5 aclk = ~aclk;
    // Oscillator at a quarter of aclk keeps divided outputs short
    always @(posedge aclk) begin
        osc_div <= osc_div + 2'h1;
        osc_32k <= osc_div[1];
        if (temp_meas_start) temp_seen <= 1'b1;
        if (switchover_stamp_req) stamp_cnt <= stamp_cnt + 1;
    end
    rcs_regs i_rcs_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tick_event(ev[0]), .watchdog_event(ev[1]), .stamp_ground_event(ev[2]), .alarm_event(ev[3]),
        .countdown_event(ev[4]), .switchover_event(ev[5]), .battery_low, .osc_32k, .irq_q, .power_mode_field,
        .switchover_stamp_req, .temp_meas_start, .square_wave_pin_out, .square_wave_pin_oe);
    rcs_host i_rcs_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
////////////////////////////////////////
    task automatic print_verdict;
        err_count += i_rcs_host.timeouts;
        if (err_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `RCS_RESP_OKAY);
        i_rcs_host.write_reg(a, d, resp);
        if (i_rcs_host.timeouts != 0) print_verdict;
        check(resp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = `RCS_RESP_OKAY);
        i_rcs_host.read_reg(a, rdat, resp);
        if (i_rcs_host.timeouts != 0) print_verdict;
        check(rdat, {24'h00_0000, e});
        check(resp, er);
    endtask
    task automatic pulse(input int i);
        @(posedge aclk) ev[i] <= 1'b1;
        @(posedge aclk) ev[i] <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    // Cycles until the pin enable changes, capped at 300
    task automatic count_run(output int n);
        logic p;
        p = square_wave_pin_oe;
        n = 0;
        while (square_wave_pin_oe === p && n < 300) begin
            @(posedge aclk);
            n++;
        end
    endtask
////////////////////////////////////////
    task automatic t_reset;
        check(temp_seen, 1'b1);
        rd(a_ev, 8'h00);
        rd(a_ck, 8'h00);
        rd(a_pw, 8'h00);
    endtask
    task automatic t_flags;
        pulse(0);
        pulse(2);
        pulse(3);
        pulse(4);
        rd(a_ev, 8'hb8);
        check(irq_q, 1'b1);
        wr(a_ev, 8'hf0);
        rd(a_ev, 8'hb0);
        wr(a_ev, 8'h00);
        rd(a_ev, 8'h00);
        check(irq_q, 1'b0);
    endtask
    task automatic t_enables;
        for (int i = 0; i < 3; i++) begin
            pulse(i + 2);
            check(irq_q, 1'b0);
            wr(a_ev, (8'h20 >> i) | (8'h04 >> i));
            repeat (2) @(posedge aclk);
            check(irq_q, 1'b1);
            wr(a_ev, 8'h04 >> i);
            repeat (2) @(posedge aclk);
            check(irq_q, 1'b0);
        end
        wr(a_ev, 8'h00);
    endtask
    task automatic t_power;
        wr(a_pw, 8'hf3);
        check(power_mode_field, 3'h7);
        battery_low <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(a_pw, 8'hf7);
        check(irq_q, 1'b1);
        wr(a_pw, 8'h00);
        rd(a_pw, 8'h04);
        check(irq_q, 1'b0);
        wr(a_pw, 8'h12);
        h1 = stamp_cnt;
        pulse(5);
        check(stamp_cnt - h1, 1);
        rd(a_pw, 8'h1e);
        check(irq_q, 1'b1);
        wr(a_pw, 8'h02);
        h1 = stamp_cnt;
        pulse(5);
        check(stamp_cnt - h1, 0);
        battery_low <= 1'b0;
        wr(a_pw, 8'h00);
        rd(a_pw, 8'h00);
    endtask
    task automatic t_bus;
        rd(8'h08, 8'h00, `RCS_RESP_SLVERR);
        wr(a_ck, 8'hff);
        rd(a_ck, 8'hc7);
        wr(8'h0d, 8'h00, `RCS_RESP_SLVERR);
        rd(a_ck, 8'hc7);
        count_run(h1);
        check(h1, 300);
        check(square_wave_pin_oe, 1'b0);
    endtask
    task automatic t_square_wave_pin;
        for (int c = 0; c < 6; c++) begin
            wr(a_ck, 8'(c));
            count_run(h1);
            count_run(h1);
            count_run(h2);
            check(h1, (c == 0) ? 2 : 4 << (c - 1));
            check(h2, (c == 0) ? 2 : 4 << (c - 1));
        end
        // 1 Hz code: no edge can fall in a short window this early in the run
        wr(a_ck, 8'h06);
        repeat (2) @(posedge aclk);
        count_run(h1);
        check(h1, 300);
    endtask
    task automatic t_watchdog;
        pulse(1);
        wr(a_ev, 8'h00);
        rd(a_ev, 8'h40);
        check(irq_q, 1'b1);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_reset;
        t_flags;
        t_enables;
        t_power;
        t_bus;
        t_square_wave_pin;
        t_watchdog;
        print_verdict;
    end
endmodule // rcs_regs_test
bind rcs_regs rcs_regs_monitor i_rcs_regs_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tick_event, .watchdog_event, .switchover_event, .irq_q,
    .switchover_stamp_req, .temp_meas_start, .square_wave_pin_out);
`default_nettype wire
